// *** core/pci_special_image.sv ***
`timescale 1ns/1ps
`include "special_image_params.svh"

// Notes on behaviour
// R1 - Software writes misc control only at setup or with all images off.
// R2 - Bits 31:28 of misc control read and write but steer nothing.
// R3 - Window field 26:24: 0 release at once, 1..6 give 16..512 clocks.
// R4 - After a coupled cycle the bus is held for the selected window.
// R5 - Each new coupled cycle restarts the window from its start.
// R6 - When the window runs out the bus is released.
// R7 - Software must not change the window during coupled cycles.
// R8 - Image is 64 Mbyte; decodes when address 31:26 equals the base field.
// R9 - Any other image that decodes wins over the special image.
// R10 - Four 16 Mbyte regions chosen by address bits 25:24.
// R11 - Top 64 Kbyte of each region goes to A16, the rest to A24.
// R12 - Program/data choice is ignored for A16 accesses.
// R13 - No block transfer modifier codes are ever produced.
// R14 - One width bit per region: 0 gives 16-bit, 1 gives 32-bit.
// R15 - One bit per region: 1 program code, 0 data code.
// R16 - One bit per region: 1 supervisor code, 0 user code.
// R17 - Image decodes only while enabled; disabled after reset.
// R18 - Writes are posted only with the posted write enable set and in memory space; off after reset.
// R19 - Space bit: 0 decodes memory space, 1 decodes I/O space.
// R20 - VME address is the low PCI bits, no offset added.
// R21 - Window code 0 releases the bus right after the cycle ends.

module pci_special_image
  import special_image_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // PCI address phase
  input wire logic pci_req_i,
  input wire logic [31:0] pci_addr_i,
  input wire logic pci_io_i,
  input wire logic pci_write_i,
  input wire logic other_hit_i,
  // Decode result
  output logic claim_o,
  output logic a16_o,
  output logic [5:0] am_o,
  output logic width32_o,
  output logic posted_o,
  output logic [23:0] vme_addr_o,
  output logic [1:0] region_o,
  // Coupled cycle tracking
  input wire logic coupled_busy_i,
  input wire logic coupled_done_i,
  output logic vme_own_o,
  output logic vme_release_o
);

  image_regs_t s_r;
  image_regs_t s_nxt;
  hold_timer_if hif ();

  logic hit;
  logic top64k;
  logic [1:0] reg_sel;
  logic [5:0] am_sel;
  logic [31:0] misc_word;
  logic [31:0] img_word;
  logic width_pick;

  // ==========================================
  // Read images of the two registers
  always_comb begin
    misc_word = 32'h0000_0000;
    misc_word[`MISC_LEGACY_HI:`MISC_LEGACY_LO] = s_r.legacy; // R2
    misc_word[`MISC_CWT_HI:`MISC_CWT_LO] = s_r.coupled_window_timer;
  end

  always_comb begin
    img_word = 32'h0000_0000;
    img_word[`IMG_EN_BIT] = s_r.en;
    img_word[`IMG_POSTED_WRITE_ENABLE_BIT] = s_r.posted_write_enable;
    img_word[`IMG_VDW_HI:`IMG_VDW_LO] = s_r.max_data_width;
    img_word[`IMG_PGM_HI:`IMG_PGM_LO] = s_r.program_data_select;
    img_word[`IMG_SUP_HI:`IMG_SUP_LO] = s_r.sup;
    img_word[`IMG_BS_HI:`IMG_BS_LO] = s_r.bs;
    img_word[`IMG_LAS_BIT] = s_r.pci_space_select;
  end

  // ==========================================
  // Address decode
  // The image only claims what no ordinary image claims
  assign hit = s_r.en // R17
    && (pci_addr_i[31:26] == s_r.bs) // R8
    && (pci_io_i == s_r.pci_space_select) // R19
    && !other_hit_i; // R9

  // Region select and A16 window at the top of the region
  assign reg_sel = pci_addr_i[25:24]; // R10
  assign top64k = (pci_addr_i[23:16] == 8'hFF); // R11
  // Width bit of the addressed region, seen by the width check
  assign width_pick = s_r.max_data_width[reg_sel]; // R14

  // Modifier code; no block transfer codes exist in this table
  always_comb begin
    if (top64k) begin
      am_sel = s_r.sup[reg_sel] ? `AM_A16_SUP : `AM_A16_USER; // R12 R16
    end else if (s_r.sup[reg_sel]) begin
      am_sel = s_r.program_data_select[reg_sel] ? `AM_A24_SUP_PGM : `AM_A24_SUP_DATA; // R15 R16
    end else begin
      am_sel = s_r.program_data_select[reg_sel] ? `AM_A24_USER_PGM : `AM_A24_USER_DATA; // R15
    end
  end

  // ==========================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 32'h0000_0000;
    s_nxt.claim = 1'b0;

    // Register writes; software keeps these still while images run
    if (reg_wr_i && reg_addr_i == `OFS_SLAVE_MISC) begin
      s_nxt.legacy = reg_wdata_i[`MISC_LEGACY_HI:`MISC_LEGACY_LO]; // R2
      s_nxt.coupled_window_timer = reg_wdata_i[`MISC_CWT_HI:`MISC_CWT_LO]; // R3
    end
    if (reg_wr_i && reg_addr_i == `OFS_SPECIAL_IMG) begin
      s_nxt.en = reg_wdata_i[`IMG_EN_BIT]; // R17
      s_nxt.posted_write_enable = reg_wdata_i[`IMG_POSTED_WRITE_ENABLE_BIT]; // R18
      s_nxt.max_data_width = reg_wdata_i[`IMG_VDW_HI:`IMG_VDW_LO]; // R14
      s_nxt.program_data_select = reg_wdata_i[`IMG_PGM_HI:`IMG_PGM_LO]; // R15
      s_nxt.sup = reg_wdata_i[`IMG_SUP_HI:`IMG_SUP_LO]; // R16
      s_nxt.bs = reg_wdata_i[`IMG_BS_HI:`IMG_BS_LO]; // R8
      s_nxt.pci_space_select = reg_wdata_i[`IMG_LAS_BIT]; // R19
    end

    // Register reads, unmapped offsets read zero
    if (reg_rd_i) begin
      case (reg_addr_i)
        `OFS_SLAVE_MISC: s_nxt.rdata = misc_word;
        `OFS_SPECIAL_IMG: s_nxt.rdata = img_word;
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Decode result is latched on each address phase
    if (pci_req_i) begin
      s_nxt.claim = hit;
      s_nxt.a16 = top64k; // R11
      s_nxt.am = am_sel; // R13
      s_nxt.w32 = s_r.max_data_width[reg_sel]; // R14
      s_nxt.region = reg_sel; // R10
      // I/O space forces coupled writes
      s_nxt.posted = s_r.posted_write_enable && pci_write_i && !s_r.pci_space_select; // R18
      if (top64k) begin
        s_nxt.vaddr = {8'h00, pci_addr_i[15:0]}; // R20
      end else begin
        s_nxt.vaddr = pci_addr_i[23:0]; // R20
      end
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '{
        legacy: `RST_LEGACY,
        coupled_window_timer: `RST_CWT,
        en: 1'b0,
        posted_write_enable: 1'b0,
        max_data_width: `RST_IMG_FIELD,
        program_data_select: `RST_IMG_FIELD,
        sup: `RST_IMG_FIELD,
        bs: 6'h00,
        pci_space_select: 1'b0,
        rdata: 32'h0000_0000,
        claim: 1'b0,
        a16: 1'b0,
        am: 6'h00,
        w32: 1'b0,
        posted: 1'b0,
        vaddr: 24'h00_0000,
        region: 2'h0
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // Bus hold timer
  assign hif.coupled_window_timer = s_r.coupled_window_timer; // R3
  assign hif.busy = coupled_busy_i;
  assign hif.done = coupled_done_i; // R4

  window_hold_timer u_hold (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .hif(hif)
  );

  // ==========================================
  // Outputs
  assign reg_rdata_o = s_r.rdata;
  assign claim_o = s_r.claim;
  assign a16_o = s_r.a16;
  assign am_o = s_r.am;
  assign width32_o = s_r.w32;
  assign posted_o = s_r.posted;
  assign vme_addr_o = s_r.vaddr;
  assign region_o = s_r.region;
  assign vme_own_o = hif.own;
  assign vme_release_o = hif.rel;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  chk_base_claim: assert property ( // R8
    pci_req_i && s_r.en && !other_hit_i && pci_io_i == s_r.pci_space_select
      && pci_addr_i[31:26] == s_r.bs |=> claim_o)
    else $error("matching access not claimed");
  chk_low_priority: assert property ( // R9
    pci_req_i && other_hit_i |=> !claim_o)
    else $error("special image claimed over another image");
  chk_disabled_idle: assert property ( // R17
    pci_req_i && !s_r.en |=> !claim_o)
    else $error("disabled image claimed access");
  chk_space_select: assert property ( // R19
    pci_req_i && pci_io_i != s_r.pci_space_select |=> !claim_o)
    else $error("access in wrong space claimed");
  chk_a16_code: assert property ( // R12
    claim_o && a16_o |-> am_o == `AM_A16_SUP || am_o == `AM_A16_USER)
    else $error("A16 access with non A16 modifier");
  chk_no_block: assert property ( // R13
    claim_o |-> am_o[1] != am_o[0])
    else $error("block transfer modifier produced");
  chk_width_pick: assert property ( // R14
    pci_req_i |=> width32_o == $past(width_pick))
    else $error("width bit not taken from selected region");
  chk_a16_addr: assert property ( // R20
    pci_req_i && pci_addr_i[23:16] == 8'hFF |=> a16_o && vme_addr_o[23:16] == 8'h00)
    else $error("A16 address not formed from low bits");
  chk_post_gate: assert property ( // R18
    pci_req_i && !s_r.posted_write_enable |=> !posted_o)
    else $error("write posted with posting disabled");
  chk_legacy_inert: assert property ( // R2
    reg_wr_i && reg_addr_i == `OFS_SLAVE_MISC ##1 reg_rd_i
      && reg_addr_i == `OFS_SLAVE_MISC |=> reg_rdata_o[31:28] == $past(reg_wdata_i[31:28], 2))
    else $error("legacy field did not read back");

  // Region, low address bits, per-region code fields, I/O posting, reserved misc bits and release
  chk_region_pick: assert property ( // R10
    pci_req_i |=> region_o == $past(reg_sel))
    else $error("region not taken from address bits 25:24");
  chk_a24_addr: assert property ( // R20
    pci_req_i && pci_addr_i[23:16] != 8'hFF
      |=> !a16_o && {8'h00, vme_addr_o} == ($past(pci_addr_i) & 32'h00FF_FFFF))
    else $error("A24 address not formed from low bits");
  chk_a24_fields: assert property ( // R15 R16
    claim_o && !a16_o |-> am_o[1] == s_r.program_data_select[region_o] && am_o[2] == s_r.sup[region_o])
    else $error("A24 modifier does not follow region fields");
  chk_posted_io: assert property ( // R18
    pci_req_i && s_r.pci_space_select |=> !posted_o)
    else $error("write posted through an I/O space image");
  chk_misc_reserved: assert property ( // R3
    reg_rd_i && reg_addr_i == `OFS_SLAVE_MISC
      |=> reg_rdata_o[27] == 1'b0 && reg_rdata_o[23:0] == 24'h00_0000)
    else $error("reserved misc bits read non zero");
  chk_release_own: assert property ( // R6
    vme_release_o |-> !vme_own_o)
    else $error("ownership still held at release pulse");

endmodule : pci_special_image

// *** core/window_hold_timer.sv ***
`timescale 1ns/1ps
`include "special_image_params.svh"

module window_hold_timer
  import special_image_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Control link
  hold_timer_if.timer hif
);

  hold_regs_t s_r;
  hold_regs_t s_nxt;
  logic [9:0] load_cnt;
  logic timed;

  // ==========================================
  // Hold interval from the window setting
  assign timed = (hif.coupled_window_timer != 3'h0) && (hif.coupled_window_timer <= `CWT_MAX_CODE);
  assign load_cnt = `CWT_BASE_CLKS << (hif.coupled_window_timer - 3'h1);

  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rel = 1'b0;
    case (s_r.st)
      HT_IDLE: begin
        if (hif.busy) begin
          s_nxt.st = HT_BUSY;
          s_nxt.own = 1'b1;
        end
      end
      HT_BUSY: begin
        if (hif.done && timed) begin
          s_nxt.st = HT_HOLD; // R4 R5
          s_nxt.cnt = load_cnt; // R3
        end else if (hif.done) begin
          s_nxt.st = HT_IDLE; // R21
          s_nxt.own = 1'b0;
          s_nxt.rel = 1'b1;
        end
      end
      HT_HOLD: begin
        if (hif.busy) begin
          s_nxt.st = HT_BUSY; // R5
        end else if (s_r.cnt == 10'h001) begin
          s_nxt.st = HT_IDLE; // R6
          s_nxt.own = 1'b0;
          s_nxt.rel = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 10'h001;
        end
      end
      default: begin
        s_nxt.st = HT_IDLE;
        s_nxt.own = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '{st: HT_IDLE, cnt: 10'h000, own: 1'b0, rel: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hif.own = s_r.own;
  assign hif.rel = s_r.rel;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  chk_zero_release: assert property ( // R21
    s_r.st == HT_BUSY && hif.done && hif.coupled_window_timer == 3'h0 |=> s_r.rel && !s_r.own)
    else $error("no release after coupled cycle with zero window");
  chk_load_count: assert property ( // R3
    s_r.st == HT_BUSY && hif.done && hif.coupled_window_timer == 3'h2 |=> s_r.cnt == 10'h020)
    else $error("hold count for code 2 is not 32");
  chk_expire_release: assert property ( // R6
    s_r.st == HT_HOLD && s_r.cnt == 10'h001 && !hif.busy |=> s_r.rel && !s_r.own)
    else $error("bus not released at window expiry");
  chk_restart_hold: assert property ( // R5
    s_r.st == HT_HOLD && hif.busy |=> s_r.st == HT_BUSY && s_r.own)
    else $error("new coupled cycle did not restart window");
  chk_hold_own: assert property ( // R4
    s_r.st == HT_HOLD |-> s_r.own)
    else $error("ownership dropped during hold window");

endmodule : window_hold_timer

// *** inc/hold_timer_if.sv ***
`timescale 1ns/1ps

// Link between the decoder top and the bus hold timer
interface hold_timer_if;
  logic [2:0] coupled_window_timer;
  logic busy;
  logic done;
  logic own;
  logic rel;
  modport timer (input coupled_window_timer, busy, done, output own, rel);
  modport ctrl (output coupled_window_timer, busy, done, input own, rel);
endinterface : hold_timer_if

// *** inc/special_image_params.svh ***
`ifndef SPECIAL_IMAGE_PARAMS_SVH
`define SPECIAL_IMAGE_PARAMS_SVH

// ==========================================
// Register offsets
`define OFS_SLAVE_MISC 12'h184
`define OFS_SPECIAL_IMG 12'h188

// ==========================================
// Miscellaneous control fields
`define MISC_LEGACY_HI 31
`define MISC_LEGACY_LO 28
`define MISC_CWT_HI 26
`define MISC_CWT_LO 24

// ==========================================
// Special image fields
`define IMG_EN_BIT 31
`define IMG_POSTED_WRITE_ENABLE_BIT 30
`define IMG_VDW_HI 23
`define IMG_VDW_LO 20
`define IMG_PGM_HI 15
`define IMG_PGM_LO 12
`define IMG_SUP_HI 11
`define IMG_SUP_LO 8
`define IMG_BS_HI 7
`define IMG_BS_LO 2
`define IMG_LAS_BIT 0

// ==========================================
// Reset values
`define RST_LEGACY 4'h0
`define RST_CWT 3'h0
`define RST_IMG_FIELD 4'h0

// ==========================================
// Address modifier codes
`define AM_A16_USER 6'h29
`define AM_A16_SUP 6'h2D
`define AM_A24_USER_DATA 6'h39
`define AM_A24_USER_PGM 6'h3A
`define AM_A24_SUP_DATA 6'h3D
`define AM_A24_SUP_PGM 6'h3E

// ==========================================
// Timing counts
`define CWT_BASE_CLKS 10'h010
`define CWT_MAX_CODE 3'h6

`endif

// *** inc/special_image_pkg.sv ***
package special_image_pkg;

  // ==========================================
  // Hold timer states
  typedef enum logic [2:0] {
    HT_IDLE = 3'b001,
    HT_BUSY = 3'b010,
    HT_HOLD = 3'b100
  } hold_state_t;

  typedef struct packed {
    hold_state_t st;
    logic [9:0] cnt;
    logic own;
    logic rel;
  } hold_regs_t;

  // ==========================================
  // Register and decode state
  typedef struct packed {
    logic [3:0] legacy;
    logic [2:0] coupled_window_timer;
    logic en;
    logic posted_write_enable;
    logic [3:0] max_data_width;
    logic [3:0] program_data_select;
    logic [3:0] sup;
    logic [5:0] bs;
    logic pci_space_select;
    logic [31:0] rdata;
    logic claim;
    logic a16;
    logic [5:0] am;
    logic w32;
    logic posted;
    logic [23:0] vaddr;
    logic [1:0] region;
  } image_regs_t;

endpackage : special_image_pkg

// *** test/pci_master_model.sv ***
`timescale 1ns/1ps

// ==========================================
// PCI master side: address phases and coupled cycles
module pci_master_model (
  // Clock
  input wire logic clk_sys_i,
  // Address phase
  output logic pci_req_o,
  output logic [31:0] pci_addr_o,
  output logic pci_io_o,
  output logic pci_write_o,
  output logic other_hit_o,
  // Coupled cycle
  output logic coupled_busy_o,
  output logic coupled_done_o
);
  // Idle values at time zero
  initial begin
    pci_req_o = 1'b0;
    pci_addr_o = 32'h0000_0000;
    pci_io_o = 1'b0;
    pci_write_o = 1'b0;
    other_hit_o = 1'b0;
    coupled_busy_o = 1'b0;
    coupled_done_o = 1'b0;
  end

  // One address phase; afterwards the address and other-hit lines no longer carry the old value, io and write keep theirs
  task automatic access(input logic [31:0] a, input logic io, input logic wr, input logic oth);
    @(posedge clk_sys_i);
    pci_req_o <= 1'b1;
    pci_addr_o <= a;
    pci_io_o <= io;
    pci_write_o <= wr;
    other_hit_o <= oth;
    @(posedge clk_sys_i);
    pci_req_o <= 1'b0;
    pci_addr_o <= ~a;
    other_hit_o <= ~oth;
  endtask : access

  // Coupled transfer: busy for two cycles, done in the cycle busy falls
  task automatic coupled();
    @(posedge clk_sys_i);
    coupled_busy_o <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    coupled_busy_o <= 1'b0;
    coupled_done_o <= 1'b1;
    @(posedge clk_sys_i);
    coupled_done_o <= 1'b0;
  endtask : coupled
endmodule : pci_master_model

// *** test/pci_slave_special_image_decode_test.sv ***
`timescale 1ns/1ps
`include "special_image_params.svh"

`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end

module pci_slave_special_image_decode_test;
  // ==========================================
  // Signals
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic pci_req_i, pci_io_i, pci_write_i, other_hit_i, coupled_busy_i, coupled_done_i;
  logic [31:0] pci_addr_i;
  logic claim_o, a16_o, width32_o, posted_o, vme_own_o, vme_release_o;
  logic [5:0] am_o;
  logic [23:0] vme_addr_o;
  logic [1:0] region_o;
  logic [31:0] a;
  logic [5:0] am_exp;
  int fails = 0;
  int compares = 0;
  // Region settings programmed below
  logic [3:0] max_data_width = 4'b0110;
  logic [3:0] program_data_select = 4'b0011;
  logic [3:0] sup = 4'b0101;

  // Clock
  always #5 clk_sys_i = ~clk_sys_i;

  // ==========================================
  // Design and far side
  pci_special_image uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pci_req_i(pci_req_i), .pci_addr_i(pci_addr_i),
    .pci_io_i(pci_io_i), .pci_write_i(pci_write_i), .other_hit_i(other_hit_i),
    .claim_o(claim_o), .a16_o(a16_o), .am_o(am_o), .width32_o(width32_o),
    .posted_o(posted_o), .vme_addr_o(vme_addr_o), .region_o(region_o),
    .coupled_busy_i(coupled_busy_i), .coupled_done_i(coupled_done_i),
    .vme_own_o(vme_own_o), .vme_release_o(vme_release_o));
  pci_master_model pm (.clk_sys_i(clk_sys_i), .pci_req_o(pci_req_i), .pci_addr_o(pci_addr_i),
    .pci_io_o(pci_io_i), .pci_write_o(pci_write_i), .other_hit_o(other_hit_i),
    .coupled_busy_o(coupled_busy_i), .coupled_done_o(coupled_done_i));

  // ==========================================
  // Register port tasks
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // Write, then read the same register in the very next cycle
  task automatic wr_rd(input logic [11:0] ad, input logic [31:0] d, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(reg_rdata_o, exp)
  endtask : wr_rd

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [11:0] ad, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(reg_rdata_o, exp)
  endtask : rd_chk

  // Address phase and claim check
  task automatic dec(input logic [31:0] ad, input logic io, input logic w, input logic oth,
    input logic ok);
    pm.access(ad, io, w, oth);
    #1;
    `CHK(claim_o, ok)
  endtask : dec

  // Edges after the one that takes done until the release pulse shows
  task automatic wait_rel(input int d);
    int n;
    n = 0;
    #1;
    if (d > 0) `CHK(vme_own_o, 1'b1)
    while (vme_release_o !== 1'b1 && n < 600) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    `CHK(n, d)
    `CHK(vme_own_o, 1'b0)
  endtask : wait_rel

  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Watchdog
  initial begin
    #100_000;
    fails++;
    give_verdict();
  end

  // ==========================================
  // Test sequence
  initial begin
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd_chk(12'h184, 32'h0000_0000);
    rd_chk(12'h188, 32'h0000_0000);
    rd_chk(12'h18C, 32'h0000_0000);
    dec(32'h0000_1000, 1'b0, 1'b1, 1'b0, 1'b0);
    // Window codes while all images are off, legacy bits set
    for (int c = 0; c < 8; c++) begin
      wr_rd(12'h184, {4'hF, 1'b1, c[2:0], 24'hFF_FFFF},
        {4'hF, 1'b0, c[2:0], 24'h00_0000});
      pm.coupled();
      wait_rel((c == 0 || c == 7) ? 0 : 16 << (c - 1));
    end
    // A second coupled cycle inside the window restarts it
    wr(12'h184, 32'h0100_0000);
    pm.coupled();
    repeat (5) @(posedge clk_sys_i);
    pm.coupled();
    wait_rel(16);
    wr(12'h184, 32'h0000_0000);
    // Image on, base 1, memory space, posting on
    wr_rd(12'h188, 32'hFF6F_3506, 32'hC060_3504);
    for (int r = 0; r < 4; r++) begin
      for (int t = 0; t < 2; t++) begin
        a = {6'h01, r[1:0], t[0] ? 8'hFF : 8'hFE, 16'hA5C3};
        dec(a, 1'b0, 1'b1, 1'b0, 1'b1);
        `CHK(region_o, r[1:0])
        `CHK(a16_o, t[0])
        `CHK(vme_addr_o, t[0] ? {8'h00, a[15:0]} : a[23:0])
        // Expected modifier from the region's fields
        if (t[0]) am_exp = sup[r] ? `AM_A16_SUP : `AM_A16_USER;
        else if (sup[r]) am_exp = program_data_select[r] ? `AM_A24_SUP_PGM : `AM_A24_SUP_DATA;
        else am_exp = program_data_select[r] ? `AM_A24_USER_PGM : `AM_A24_USER_DATA;
        `CHK(am_o, am_exp)
        `CHK(width32_o, max_data_width[r])
        `CHK(posted_o, 1'b1)
      end
    end
    dec(32'h0400_0010, 1'b0, 1'b0, 1'b0, 1'b1);
    `CHK(posted_o, 1'b0)
    dec(32'h0400_0010, 1'b0, 1'b1, 1'b1, 1'b0);
    dec(32'h0800_0010, 1'b0, 1'b1, 1'b0, 1'b0);
    dec(32'h07FF_FFFC, 1'b1, 1'b1, 1'b0, 1'b0);
    // I/O space image
    wr(12'h188, 32'hC060_3505);
    dec(32'h0500_0000, 1'b1, 1'b1, 1'b0, 1'b1);
    `CHK(posted_o, 1'b0)
    dec(32'h0500_0000, 1'b0, 1'b1, 1'b0, 1'b0);
    give_verdict();
  end
endmodule : pci_slave_special_image_decode_test
